/* File: design/hufc_uart.sv */
// Host serial port with request/clear-to-send flow control
`timescale 1ns/1ps
`include "hufc_consts.svh"
module hufc_uart #(
  parameter int          DATA_BITS = 8,
  parameter int          FIFO_DEPTH = 4,
  parameter logic [15:0] BAUD_DIV = `HUFC_BAUD_DIV_DEF,
  parameter int          PWRUP_CYC = `HUFC_PWRUP_CYC
) (
  // Clock and reset
  input  wire logic       clock_i,
  input  wire logic       rst_b_i,
  // Pins
  input  wire logic       power_down_hold_low_i,
  input  wire logic       rx_pin_i,
  input  wire logic       cts_pin_i,
  output logic            tx_pin_o,
  output logic            rts_pin_o,
  // Options
  input  wire logic       par_en_i,
  input  wire logic       par_odd_i,
  // Transmit user side
  input  wire logic       tx_valid_i,
  input  wire logic [7:0] tx_data_i,
  output logic            tx_ready_o,
  // Receive user side
  output logic            rx_valid_o,
  input  wire logic       rx_ready_i,
  output hufc_pkg::hufc_rx_t rx_data_o,
  output logic            ready_o
);
  // --------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------
  logic [2:0] rx_s_reg, cts_s_reg, pd_s_reg;
  logic rx_q_reg, cts_q_reg, pd_q_reg;
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rx_s_reg  <= 3'h7;
      cts_s_reg <= 3'h7;
      pd_s_reg  <= 3'h0;
      rx_q_reg  <= 1'b1;
      cts_q_reg <= 1'b1;
      pd_q_reg  <= 1'b0;
    end else begin
      rx_s_reg  <= {rx_s_reg[1:0], rx_pin_i};
      cts_s_reg <= {cts_s_reg[1:0], cts_pin_i};
      pd_s_reg  <= {pd_s_reg[1:0], power_down_hold_low_i};
      if (rx_s_reg[2] == rx_s_reg[1])   rx_q_reg  <= rx_s_reg[2];
      if (cts_s_reg[2] == cts_s_reg[1]) cts_q_reg <= cts_s_reg[2];
      if (pd_s_reg[2] == pd_s_reg[1])   pd_q_reg  <= pd_s_reg[2];
    end
  end
  // --------------------------------------------------------------
  // Oversampling tick, 16 per bit
  // --------------------------------------------------------------
  logic [15:0] div_reg;
  wire tick = (div_reg == BAUD_DIV - 16'h0001);
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) div_reg <= 16'h0;
    else div_reg <= tick ? 16'h0 : div_reg + 16'h0001;
  end
  // --------------------------------------------------------------
  // Power-up: hold everything until the count after release ends
  // --------------------------------------------------------------
  logic [31:0] pu_reg;
  logic        up_reg;
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pu_reg <= 32'h0;
      up_reg <= 1'b0;
    end else if (!pd_q_reg) begin
      pu_reg <= 32'h0;
      up_reg <= 1'b0;
    end else if (!up_reg) begin
      pu_reg <= pu_reg + 32'h1;
      up_reg <= (pu_reg >= 32'(PWRUP_CYC - 1));
    end
  end
  // --------------------------------------------------------------
  // Transmit: clear-to-send gating and resume delay
  // --------------------------------------------------------------
  logic [15:0] cts_cnt_reg;
  logic        tx_ok_reg;
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cts_cnt_reg <= 16'h0;
      tx_ok_reg   <= 1'b0;
    end else if (cts_q_reg) begin
      cts_cnt_reg <= 16'h0;
      tx_ok_reg   <= 1'b0;
    end else if (cts_cnt_reg != 16'(`HUFC_RESUME_CYC)) begin
      cts_cnt_reg <= cts_cnt_reg + 16'h1;
    end else begin
      tx_ok_reg <= 1'b1;
    end
  end
  hufc_pkg::hufc_st_t tst_reg;
  logic [3:0]  tph_reg;
  logic [3:0]  tbit_reg;
  logic [7:0]  tsh_reg;
  logic        tpar_reg;
  // A character already started finishes; only new starts are held back
  // Take only on a shown ready, so a held request is never taken twice
  wire tx_take = tx_valid_i && tx_ready_o;
  wire tbit_end = tick && (tph_reg == 4'(`HUFC_OVS_LAST));
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tst_reg <= hufc_pkg::HUFC_IDLE;
      tph_reg <= 4'h0; tbit_reg <= 4'h0; tsh_reg <= 8'h0;
      tpar_reg <= 1'b0; tx_pin_o <= 1'b1; tx_ready_o <= 1'b0;
    end else begin
      tx_ready_o <= up_reg && tx_ok_reg && (tst_reg == hufc_pkg::HUFC_IDLE)
                    && !tx_take;
      if (tick) tph_reg <= tph_reg + 4'h1;
      case (tst_reg)
        hufc_pkg::HUFC_IDLE: begin
          tx_pin_o <= 1'b1;
          if (tx_take) begin
            tsh_reg  <= tx_data_i;
            tpar_reg <= par_odd_i;
            tph_reg  <= 4'h0;
            tbit_reg <= 4'h0;
            tx_pin_o <= 1'b0;
            tst_reg  <= hufc_pkg::HUFC_START;
          end
        end
        hufc_pkg::HUFC_START:
          if (tbit_end) begin
            tx_pin_o <= tsh_reg[0];
            tst_reg  <= hufc_pkg::HUFC_DATA;
          end
        hufc_pkg::HUFC_DATA:
          if (tbit_end) begin
            tpar_reg <= tpar_reg ^ tsh_reg[0];
            tsh_reg  <= {1'b0, tsh_reg[7:1]};
            tbit_reg <= tbit_reg + 4'h1;
            if (tbit_reg == 4'(DATA_BITS - 1)) begin
              tx_pin_o <= par_en_i ? (tpar_reg ^ tsh_reg[0]) : 1'b1;
              tst_reg  <= par_en_i ? hufc_pkg::HUFC_PAR
                                   : hufc_pkg::HUFC_STOP;
            end else begin
              tx_pin_o <= tsh_reg[1];
            end
          end
        hufc_pkg::HUFC_PAR:
          if (tbit_end) begin
            tx_pin_o <= 1'b1;
            tst_reg  <= hufc_pkg::HUFC_STOP;
          end
        hufc_pkg::HUFC_STOP:
          if (tbit_end) tst_reg <= hufc_pkg::HUFC_IDLE;
        default: tst_reg <= hufc_pkg::HUFC_IDLE;
      endcase
    end
  end
  // --------------------------------------------------------------
  // Receive: centre sampling into the FIFO
  // --------------------------------------------------------------
  hufc_pkg::hufc_st_t rst_st_reg;
  logic [3:0] rph_reg;
  logic [3:0] rbit_reg;
  logic [7:0] rsh_reg;
  logic       rpar_reg;
  logic       rperr_reg;
  logic       rpush_reg;
  hufc_pkg::hufc_rx_t rword_reg;
  logic [$clog2(FIFO_DEPTH+1)-1:0] f_level;
  wire rmid = tick && (rph_reg == 4'(`HUFC_OVS_MID));
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_st_reg <= hufc_pkg::HUFC_IDLE;
      rph_reg <= 4'h0; rbit_reg <= 4'h0; rsh_reg <= 8'h0;
      rpar_reg <= 1'b0; rperr_reg <= 1'b0; rpush_reg <= 1'b0;
      rword_reg <= '0;
    end else begin
      if (tick) rph_reg <= rph_reg + 4'h1;
      rpush_reg <= 1'b0;
      case (rst_st_reg)
        hufc_pkg::HUFC_IDLE:
          if (up_reg && !rx_q_reg) begin
            rph_reg    <= 4'h0;
            rst_st_reg <= hufc_pkg::HUFC_START;
          end
        hufc_pkg::HUFC_START:
          if (rmid) begin
            rbit_reg <= 4'h0; rpar_reg <= par_odd_i; rperr_reg <= 1'b0;
            rst_st_reg <= rx_q_reg ? hufc_pkg::HUFC_IDLE
                                   : hufc_pkg::HUFC_DATA;
          end
        hufc_pkg::HUFC_DATA:
          if (rmid) begin
            rsh_reg  <= {rx_q_reg, rsh_reg[7:1]};
            rpar_reg <= rpar_reg ^ rx_q_reg;
            rbit_reg <= rbit_reg + 4'h1;
            if (rbit_reg == 4'(DATA_BITS - 1))
              rst_st_reg <= par_en_i ? hufc_pkg::HUFC_PAR
                                     : hufc_pkg::HUFC_STOP;
          end
        hufc_pkg::HUFC_PAR:
          if (rmid) begin
            rperr_reg  <= rpar_reg ^ rx_q_reg;
            rst_st_reg <= hufc_pkg::HUFC_STOP;
          end
        hufc_pkg::HUFC_STOP:
          if (rmid) begin
            // A full FIFO drops the character; host should have stopped
            rword_reg  <= '{data: rsh_reg >> (8 - DATA_BITS),
                            par_err: rperr_reg, frm_err: !rx_q_reg};
            rpush_reg  <= 1'b1;
            rst_st_reg <= hufc_pkg::HUFC_IDLE;
          end
        default: rst_st_reg <= hufc_pkg::HUFC_IDLE;
      endcase
    end
  end
  logic f_valid;
  hufc_pkg::hufc_rx_t f_data;
  hufc_fifo #(.WIDTH($bits(hufc_pkg::hufc_rx_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clock_i     (clock_i),
    .rst_b_i     (rst_b_i),
    .in_valid_i  (rpush_reg),
    .in_ready_o  (),
    .in_data_i   (rword_reg),
    .out_valid_o (f_valid),
    .out_ready_i (rx_ready_i),
    .out_data_o  (f_data),
    .level_o     (f_level)
  );
  assign rx_valid_o = f_valid;
  assign rx_data_o  = f_data;
  // --------------------------------------------------------------
  // Request-to-send: high in power-up and at quarter fill
  // --------------------------------------------------------------
  wire quarter = (32'(f_level) * `HUFC_RTS_FRAC >= 32'(FIFO_DEPTH))
                 && (f_level != '0);
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rts_pin_o <= 1'b1;
      ready_o   <= 1'b0;
    end else begin
      rts_pin_o <= !up_reg || quarter;
      ready_o   <= up_reg;
    end
  end
endmodule : hufc_uart

/* File: include/hufc_consts.svh */
// Constants for the host serial port with hardware flow control
`ifndef HUFC_CONSTS_SVH
`define HUFC_CONSTS_SVH
`define HUFC_CLK_HZ        250000000
`define HUFC_BAUD_KBPS     4000
`define HUFC_OVS           16
`define HUFC_OVS_MID       7
`define HUFC_OVS_LAST      15
`define HUFC_RESUME_NS     2000
`define HUFC_CLK_NS        4
`define HUFC_RESUME_CYC    (`HUFC_RESUME_NS / `HUFC_CLK_NS)
`define HUFC_PWRUP_MS      100
`define HUFC_PWRUP_CYC     (`HUFC_PWRUP_MS * 250000)
`define HUFC_BAUD_DIV_DEF  4
`define HUFC_RTS_FRAC      4
`endif

/* File: include/hufc_pkg.sv */
// Types shared by the host serial port
package hufc_pkg;
  typedef struct packed {
    logic [7:0] data;
    logic       par_err;
    logic       frm_err;
  } hufc_rx_t;
  typedef enum logic [4:0] {
    HUFC_IDLE  = 5'h01,
    HUFC_START = 5'h02,
    HUFC_DATA  = 5'h04,
    HUFC_PAR   = 5'h08,
    HUFC_STOP  = 5'h10
  } hufc_st_t;
endpackage : hufc_pkg

/* File: design/hufc_fifo.sv */
// Small valid/ready FIFO in the receive path
`timescale 1ns/1ps
module hufc_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic             clock_i,
  input  wire logic             rst_b_i,
  // Fill side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o,
  // Fill level
  output logic [$clog2(DEPTH+1)-1:0] level_o
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH+1);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_reg;
  logic [AW-1:0]    rd_reg;
  logic [CW-1:0]    cnt_reg;
  wire push = in_valid_i && in_ready_o;
  wire pop  = out_valid_o && out_ready_i;
  assign in_ready_o  = (cnt_reg != CW'(DEPTH));
  assign out_valid_o = (cnt_reg != '0);
  assign out_data_o  = mem_reg[rd_reg];
  assign level_o     = cnt_reg;
  always_ff @(posedge clock_i) begin
    if (push) mem_reg[wr_reg] <= in_data_i;
  end
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) wr_reg <= (wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + 1'b1;
      if (pop)  rd_reg <= (rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + 1'b1;
      cnt_reg <= cnt_reg + CW'(push) - CW'(pop);
    end
  end
endmodule : hufc_fifo

/* File: tb/hufc_host_model.sv */
// Host-side serial partner with flow control
`timescale 1ns/1ps
module hufc_host_model #(
  parameter int BIT_CYC = 64
) (
  // Clock and lines
  input  wire logic clock_i,
  input  wire logic line_i,
  input  wire logic rts_i,
  input  wire logic par_en_i,
  input  wire logic par_odd_i,
  output logic      line_o
);
  logic [9:0] got_q[$];
  logic [9:0] fr;
  initial line_o = 1'b1;
  // Early chars skip the RTS wait; the device tolerates up to 4
  task automatic send(input logic [7:0] d, input logic early);
    logic [10:0] f;
    f = {1'b1, ^d ^ par_odd_i, d, 1'b0};
    while (!early && rts_i) @(posedge clock_i);
    for (int i = 0; i < 11; i++) begin
      if (i != 9 || par_en_i) begin
        line_o <= f[i];
        repeat (BIT_CYC) @(posedge clock_i);
      end
    end
  endtask : send
  // Stored as stop, parity, data; parity reads 0 when disabled
  initial forever begin
    @(negedge line_i);
    repeat (BIT_CYC / 2) @(posedge clock_i);
    for (int i = 0; i < 10; i++) begin
      if (i == 8 && !par_en_i) fr[8] = 1'b0;
      else begin
        repeat (BIT_CYC) @(posedge clock_i);
        fr[i] = line_i;
      end
    end
    got_q.push_back(fr);
  end
endmodule : hufc_host_model

/* File: tb/hufc_uart_sva.sv */
// Pin and user-handshake checks for the host serial port
`timescale 1ns/1ps
module hufc_uart_sva #(
  parameter int          PWRUP_CYC = 20,
  parameter logic [15:0] BAUD_DIV  = 16'h0004
) (
  input wire logic               clock_i,
  input wire logic               rst_b_i,
  input wire logic               power_down_hold_low_i,
  input wire logic               rx_pin_i,
  input wire logic               cts_pin_i,
  input wire logic               tx_pin_o,
  input wire logic               rts_pin_o,
  input wire logic               par_en_i,
  input wire logic               par_odd_i,
  input wire logic               tx_valid_i,
  input wire logic [7:0]         tx_data_i,
  input wire logic               tx_ready_o,
  input wire logic               rx_valid_o,
  input wire logic               rx_ready_i,
  input wire hufc_pkg::hufc_rx_t rx_data_o,
  input wire logic               ready_o
);
  localparam int PU_MAX = PWRUP_CYC + 16;
  // Start bit may lose up to one tick, as it starts off the tick grid
  localparam int BIT_M12 = 16 * BAUD_DIV - 12;
  localparam int SLACK   = BAUD_DIV + 1;
  // Cycles since clear-to-send was last high, saturating
  logic [9:0] lo_cnt_reg;
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) lo_cnt_reg <= 10'h3ff;
    else if (cts_pin_i) lo_cnt_reg <= 10'h000;
    else if (lo_cnt_reg != 10'h3ff) lo_cnt_reg <= lo_cnt_reg + 10'h001;
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  pwr_up_a: assert property ($rose(power_down_hold_low_i) |->
    ##[1:PU_MAX] !rts_pin_o) else $error("power-up not reported");
  off_idle_a: assert property (!ready_o |-> tx_pin_o && rts_pin_o)
    else $error("pins active before power-up done");
  start_bit_a: assert property (tx_valid_i && tx_ready_o
    && tx_data_i[0] |=> !tx_pin_o [*8] ##BIT_M12 !tx_pin_o
    ##[1:SLACK] tx_pin_o)
    else $error("start bit length or first data bit wrong");
  cts_stop_a: assert property (cts_pin_i [*8] |-> !tx_ready_o)
    else $error("transmit accepted while clear-to-send high");
  cts_resume_a: assert property (tx_ready_o |->
    lo_cnt_reg < 10'h008 || lo_cnt_reg >= 10'h1f4)
    else $error("transmit resumed too early");
  rts_full_a: assert property (rx_valid_o && $past(rx_valid_o)
    |-> rts_pin_o) else $error("request-to-send low with data held");
  rts_clear_a: assert property (ready_o && $past(ready_o)
    && !rx_valid_o && !$past(rx_valid_o) |-> !rts_pin_o)
    else $error("request-to-send high with empty buffer");
  rx_hold_a: assert property (rx_valid_o && !rx_ready_i |=>
    rx_valid_o && $stable(rx_data_o)) else $error("receive data dropped");
  cover property (tx_valid_i && tx_ready_o && par_en_i);
  cover property (rx_valid_o && rx_ready_i);
  cover property ($fell(cts_pin_i));
endmodule : hufc_uart_sva
bind hufc_uart hufc_uart_sva #(
  .PWRUP_CYC(PWRUP_CYC),
  .BAUD_DIV (BAUD_DIV)
) chk_u (.*);

/* File: tb/tb_hufc_uart.sv */
// Self-checking bench for the host serial port
`timescale 1ns/1ps
module tb_hufc_uart;
  logic clock_i, rst_b_i, power_down_hold_low_i, rx_pin_i, cts_pin_i;
  logic tx_pin_o, rts_pin_o, par_en_i, par_odd_i, tx_valid_i, tx_ready_o;
  logic rx_valid_o, rx_ready_i, ready_o;
  logic [7:0] tx_data_i;
  hufc_pkg::hufc_rx_t rx_data_o;
  int fail_count, checks_done, n;
  hufc_uart #(.PWRUP_CYC(20)) dut_u (.*);
  hufc_host_model host_u (.clock_i(clock_i), .line_i(tx_pin_o),
    .rts_i(rts_pin_o), .par_en_i(par_en_i), .par_odd_i(par_odd_i),
    .line_o(rx_pin_i));
  initial begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end
  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_val
  task automatic tally_and_finish;
    $display("checks=%0d mismatches=%0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish
  // Request held until the edge that samples ready high
  task automatic put(input logic [7:0] d, output int w);
    tx_data_i <= d;
    tx_valid_i <= 1'b1;
    w = 0;
    do begin
      @(posedge clock_i);
      w++;
    end while (!tx_ready_o && w < 3000);
    tx_valid_i <= 1'b0;
    // Let an edge pass so back-to-back calls never drive valid twice at once
    @(posedge clock_i);
  endtask : put
  task automatic wait_q(input int k);
    for (n = 0; n < 4000 && host_u.got_q.size() < k; n++) @(posedge clock_i);
  endtask : wait_q
  task automatic t_pwrup;
    chk_val(rts_pin_o, 1);
    power_down_hold_low_i <= 1'b1;
    for (n = 0; n < 200 && !ready_o; n++) @(posedge clock_i);
    chk_val(ready_o, 1);
    chk_val(rts_pin_o, 0);
    $display("test power-up done");
  endtask : t_pwrup
  task automatic t_tx;
    int w;
    logic [7:0] d;
    logic p;
    for (int m = 0; m < 3; m++) begin
      par_en_i <= (m != 0);
      par_odd_i <= (m == 2);
      host_u.got_q.delete();
      put(8'ha5, w);
      put(8'h3c, w);
      wait_q(2);
      chk_val(host_u.got_q.size(), 2);
      foreach (host_u.got_q[i]) begin
        d = i ? 8'h3c : 8'ha5;
        p = (m != 0) & (^d ^ (m == 2));
        chk_val(host_u.got_q[i], {1'b1, p, d});
      end
    end
    $display("test tx frames done");
  endtask : t_tx
  task automatic t_cts;
    int w;
    par_en_i <= 1'b0;
    host_u.got_q.delete();
    put(8'h5a, w);
    repeat (10) @(posedge clock_i);
    cts_pin_i <= 1'b1;
    tx_data_i <= 8'h81;
    tx_valid_i <= 1'b1;
    repeat (1600) @(posedge clock_i);
    chk_val(host_u.got_q.size(), 1);
    cts_pin_i <= 1'b0;
    put(8'h81, w);
    chk_val(w >= 500, 1);
    wait_q(2);
    chk_val(host_u.got_q[1], {2'b10, 8'h81});
    $display("test clear-to-send done");
  endtask : t_cts
  task automatic t_rx;
    par_en_i <= 1'b1;
    rx_ready_i <= 1'b0;
    @(posedge clock_i);
    for (int i = 0; i < 5; i++) host_u.send(8'h10 + 8'(i), 1'b1);
    repeat (100) @(posedge clock_i);
    chk_val(rts_pin_o, 1);
    for (int i = 0; i < 4; i++) begin
      chk_val(rx_valid_o, 1);
      chk_val(rx_data_o, {8'h10 + 8'(i), 2'b00});
      rx_ready_i <= 1'b1;
      @(posedge clock_i);
      rx_ready_i <= 1'b0;
      @(posedge clock_i);
    end
    chk_val(rx_valid_o, 0);
    repeat (4) @(posedge clock_i);
    chk_val(rts_pin_o, 0);
    host_u.send(8'hc3, 1'b0);
    repeat (100) @(posedge clock_i);
    chk_val(rx_data_o, {8'hc3, 2'b00});
    rx_ready_i <= 1'b1;
    $display("test receive buffer done");
  endtask : t_rx
  initial begin
    {rst_b_i, power_down_hold_low_i, cts_pin_i, par_en_i, par_odd_i} = '0;
    {tx_valid_i, rx_ready_i, tx_data_i} = '0;
    fail_count = 0;
    checks_done = 0;
    repeat (4) @(posedge clock_i);
    rst_b_i <= 1'b1;
    @(posedge clock_i);
    t_pwrup;
    t_tx;
    t_cts;
    t_rx;
    tally_and_finish;
  end
  initial begin
    #200000;
    fail_count++;
    tally_and_finish;
  end
endmodule : tb_hufc_uart
